// ---- rtl/lfm_pkg.sv ----
package lfm_pkg;

	// ****************************************
	// sizes and timing
	// ****************************************
	localparam int NUM_CH = 6;
	localparam int CLK_PERIOD_NS = 50;
	localparam int ENABLE_LOW_TIME_NS = 30500000;
	localparam int OPEN_HOT_TIME_NS = 800000;
	// least time: round up
	localparam int ENABLE_LOW_CYC = (ENABLE_LOW_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// longest time: round down
	localparam int OPEN_HOT_CYC = OPEN_HOT_TIME_NS / CLK_PERIOD_NS;
	localparam int EN_CNT_W = 20;
	localparam int OPEN_CNT_W = 14;
	localparam logic [2:0] FAULT_PWM_CYCLES = 3'h6;

	// ****************************************
	// reset values and derating steps
	// ****************************************
	localparam logic [1:0] DERATE_FULL = 2'h0;
	localparam logic [1:0] DERATE_LAST = 2'h3;

	// ****************************************
	// types
	// ****************************************
	typedef enum logic [2:0] {
		ST_OFF,
		ST_STARTUP,
		ST_RUN,
		ST_THERMAL,
		ST_SHUTDOWN
	} lfm_state_e;

	// comparator levels, synchronised before use
	typedef struct packed {
		logic chipEnable;
		logic supplyLockout;
		logic boostOutputVoltageAtLimit;
		logic overvoltageSenseHigh;
		logic tempLower;
		logic tempUpper;
		logic tempCooled;
		logic boostSwitchNodeHigh;
		logic [NUM_CH-1:0] ledChannelAtTarget;
		logic [NUM_CH-1:0] channelShortDetect;
	} lfm_in_s;

	typedef struct packed {
		lfm_state_e fsm;
		logic [NUM_CH-1:0] good;
		logic [NUM_CH-1:0] openDet;
		logic [NUM_CH-1:0] chanOff;
		logic [NUM_CH-1:0][OPEN_CNT_W-1:0] openCnt;
		logic [NUM_CH-1:0][2:0] shortCnt;
		logic [1:0] derate;
		logic [EN_CNT_W-1:0] enLowCnt;
		logic senseArmed;
		logic swOn;
		logic [NUM_CH-1:0] chanEnable;
		logic active;
		logic fault;
		logic protectOff;
		logic inject;
	} lfm_st_s;

endpackage

// ---- rtl/lfm_sync_bank.sv ----
module lfm_sync_bank (
	input wire logic clk,
	input wire logic rst,
	input wire lfm_pkg::lfm_in_s raw,
	output lfm_pkg::lfm_in_s synced
);

	typedef struct packed {
		lfm_pkg::lfm_in_s stage1;
		lfm_pkg::lfm_in_s stage2;
	} lfm_sync_s;

	lfm_sync_s st;
	lfm_sync_s next_st;

	// ****************************************
	// two-flop synchroniser
	// ****************************************
	always_comb
	begin
		next_st = st;
		next_st.stage1 = raw;
		next_st.stage2 = st.stage1;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			st <= '0;
		end
		else
		begin
			st <= next_st;
		end
	end

	assign synced = st.stage2;

endmodule

// ---- rtl/lfm_fault_manager.sv ----
// How it works
// - channel reaching target current becomes good
// - good channel dropping below target becomes open
// - boost limit or lower temp opens non-good
// - open channel disabled only after time-out
// - hot time-out lasts 800 microseconds
// - lower temp trip marks weak channels open
// - upper temp stops boost and channels
// - resume after cooling, derate 75/50/25 percent
// - thermal trips keep device active
// - zener-bypassed channel kept unless boost limit or lower temp
// - supply lockout halts switching and resets
// - over-limit switch off for rest of cycle
// - startup injects current until node above 1.2V
// - sense rise then fall cuts protection FET
// - high-voltage short disabled after six PWM cycles
// - low-voltage short stays enabled
// - fault flag latches until power or re-enable
// - enable low 30.5 ms shuts device down
module lfm_fault_manager #(
	parameter logic [lfm_pkg::EN_CNT_W-1:0] ENABLE_LOW_CYCLES =
		lfm_pkg::EN_CNT_W'(lfm_pkg::ENABLE_LOW_CYC),
	parameter logic [lfm_pkg::OPEN_CNT_W-1:0] OPEN_HOT_CYCLES =
		lfm_pkg::OPEN_CNT_W'(lfm_pkg::OPEN_HOT_CYC)
) (
	input wire logic clk,
	input wire logic rst,
	input wire lfm_pkg::lfm_in_s sense,
	input wire logic switchRequest,
	input wire logic switchCycleStart,
	input wire logic switchOverLimit,
	input wire logic pwmCycleStart,
	output logic boostSwitchOn,
	output logic [lfm_pkg::NUM_CH-1:0] channelEnable,
	output logic [lfm_pkg::NUM_CH-1:0] channelGood,
	output logic [1:0] currentDerate,
	output logic faultFlag,
	output logic protectFetOff,
	output logic boostSwitchNodeInject,
	output logic deviceActive
);

	// ****************************************
	// input synchronisation
	// ****************************************
	lfm_pkg::lfm_in_s in;

	lfm_sync_bank u_sync (
		.clk(clk),
		.rst(rst),
		.raw(sense),
		.synced(in)
	);

	// ****************************************
	// state
	// ****************************************
	lfm_pkg::lfm_st_s st;
	lfm_pkg::lfm_st_s next_st;
	logic enLowExpired;
	logic hotMode;

	assign enLowExpired = (st.enLowCnt == ENABLE_LOW_CYCLES);
	assign hotMode = in.tempLower;

	// ****************************************
	// next state
	// ****************************************
	always_comb
	begin
		next_st = st;

		// enable low time
		if (in.chipEnable)
		begin
			next_st.enLowCnt = '0;
		end
		else if (!enLowExpired)
		begin
			next_st.enLowCnt = st.enLowCnt + 1'b1;
		end

		unique case (st.fsm)
			lfm_pkg::ST_OFF:
			begin
				if (in.chipEnable)
				begin
					next_st.fault = 1'b0;
					next_st.derate = lfm_pkg::DERATE_FULL;
					next_st.good = '0;
					next_st.openDet = '0;
					next_st.chanOff = '0;
					next_st.openCnt = '0;
					next_st.shortCnt = '0;
					next_st.senseArmed = 1'b0;
					next_st.fsm = lfm_pkg::ST_STARTUP;
				end
			end

			lfm_pkg::ST_STARTUP:
			begin
				// wait for the switch node to charge
				if (in.boostSwitchNodeHigh)
				begin
					next_st.fsm = lfm_pkg::ST_RUN;
				end
			end

			lfm_pkg::ST_RUN:
			begin
				for (int i = 0; i < lfm_pkg::NUM_CH; i++)
				begin
					if (!st.chanOff[i])
					begin
						// classification
						if (in.ledChannelAtTarget[i] && !st.openDet[i])
						begin
							// current held keeps it good
							next_st.good[i] = 1'b1;
						end
						else if (st.good[i] && !in.ledChannelAtTarget[i])
						begin
							next_st.good[i] = 1'b0;
							next_st.openDet[i] = 1'b1;
						end
						else if (!st.good[i] && !in.ledChannelAtTarget[i] &&
							(in.boostOutputVoltageAtLimit || in.tempLower))
						begin
							next_st.openDet[i] = 1'b1;
						end

						// open time-out
						if (st.openDet[i])
						begin
							if (hotMode)
							begin
								if (st.openCnt[i] >= OPEN_HOT_CYCLES - 1'b1)
								begin
									next_st.chanOff[i] = 1'b1;
									next_st.fault = 1'b1;
								end
								else
								begin
									next_st.openCnt[i] = st.openCnt[i] + 1'b1;
								end
							end
							else if (pwmCycleStart)
							begin
								if (st.openCnt[i] >= lfm_pkg::OPEN_CNT_W'(
									lfm_pkg::FAULT_PWM_CYCLES - 3'h1))
								begin
									next_st.chanOff[i] = 1'b1;
									next_st.fault = 1'b1;
								end
								else
								begin
									next_st.openCnt[i] = st.openCnt[i] + 1'b1;
								end
							end
						end

						// pin voltage short time-out
						if (in.channelShortDetect[i])
						begin
							if (pwmCycleStart)
							begin
								if (st.shortCnt[i] == lfm_pkg::FAULT_PWM_CYCLES - 3'h1)
								begin
									next_st.chanOff[i] = 1'b1;
									next_st.fault = 1'b1;
								end
								else
								begin
									next_st.shortCnt[i] = st.shortCnt[i] + 3'h1;
								end
							end
						end
						else
						begin
							// low short keeps conducting
							next_st.shortCnt[i] = 3'h0;
						end
					end
				end

				if (in.tempUpper)
				begin
					next_st.fsm = lfm_pkg::ST_THERMAL;
					next_st.fault = 1'b1;
					if (st.derate != lfm_pkg::DERATE_LAST)
					begin
						next_st.derate = st.derate + 2'h1;
					end
				end
			end

			lfm_pkg::ST_THERMAL:
			begin
				if (in.tempCooled && !in.tempUpper)
				begin
					// re-qualify channels after the restart ramp
					next_st.fsm = lfm_pkg::ST_RUN;
					next_st.good = '0;
					next_st.openDet = '0;
					next_st.openCnt = '0;
					next_st.shortCnt = '0;
				end
			end

			lfm_pkg::ST_SHUTDOWN:
			begin
				next_st.fsm = lfm_pkg::ST_SHUTDOWN;
			end

			default:
			begin
				next_st.fsm = lfm_pkg::ST_OFF;
			end
		endcase

		// output short watch on the sense divider
		if (st.fsm == lfm_pkg::ST_STARTUP || st.fsm == lfm_pkg::ST_RUN ||
			st.fsm == lfm_pkg::ST_THERMAL)
		begin
			if (in.overvoltageSenseHigh)
			begin
				next_st.senseArmed = 1'b1;
			end
			else if (st.senseArmed)
			begin
				next_st.fsm = lfm_pkg::ST_SHUTDOWN;
				next_st.protectOff = 1'b1;
				next_st.fault = 1'b1;
			end
		end

		if (enLowExpired && st.fsm != lfm_pkg::ST_OFF)
		begin
			next_st.fsm = lfm_pkg::ST_OFF;
			next_st.protectOff = 1'b0;
		end

		// registered outputs
		next_st.active = (next_st.fsm != lfm_pkg::ST_OFF) &&
			(next_st.fsm != lfm_pkg::ST_SHUTDOWN);
		next_st.inject = (next_st.fsm == lfm_pkg::ST_STARTUP);
		if (next_st.fsm == lfm_pkg::ST_RUN)
		begin
			next_st.chanEnable = ~next_st.chanOff;
		end
		else
		begin
			next_st.chanEnable = '0;
		end

		// cycle-by-cycle switch limit
		if (next_st.fsm != lfm_pkg::ST_RUN || switchOverLimit)
		begin
			next_st.swOn = 1'b0;
		end
		else if (switchCycleStart)
		begin
			next_st.swOn = switchRequest;
		end
		else if (!switchRequest)
		begin
			next_st.swOn = 1'b0;
		end

		// lockout holds everything in reset
		if (in.supplyLockout)
		begin
			next_st = '0;
		end
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			st <= '0;
		end
		else
		begin
			st <= next_st;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign boostSwitchOn = st.swOn;
	assign channelEnable = st.chanEnable;
	assign channelGood = st.good;
	assign currentDerate = st.derate;
	assign faultFlag = st.fault;
	assign protectFetOff = st.protectOff;
	assign boostSwitchNodeInject = st.inject;
	assign deviceActive = st.active;

endmodule

// ---- tb/lfm_chk.sv ----
module lfm_chk (
	input wire logic clk,
	input wire logic rst,
	input wire lfm_pkg::lfm_in_s sense,
	input wire logic switchRequest,
	input wire logic switchOverLimit,
	input wire logic boostSwitchOn,
	input wire logic [lfm_pkg::NUM_CH-1:0] channelEnable,
	input wire logic [lfm_pkg::NUM_CH-1:0] channelGood,
	input wire logic [1:0] currentDerate,
	input wire logic faultFlag,
	input wire logic protectFetOff,
	input wire logic boostSwitchNodeInject,
	input wire logic deviceActive
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// ****************************************
	// sequences
	// ****************************************
	sequence lockHeld;
		sense.supplyLockout[*4];
	endsequence
	sequence noLock;
		!sense.supplyLockout[*4];
	endsequence
	// ****************************************
	// assertions
	// ****************************************
	a_limit_cuts_switch: assert property (switchOverLimit |=> !boostSwitchOn)
		else $error("switch on after over-limit");
	a_no_request_off: assert property (!switchRequest |=> !boostSwitchOn)
		else $error("switch on without request");
	a_fault_latched: assert property (noLock ##0 (faultFlag && deviceActive) |=> faultFlag)
		else $error("fault flag cleared while active");
	a_lockout_halts: assert property (lockHeld |=> !deviceActive && channelEnable == '0
		&& !boostSwitchOn) else $error("lockout did not halt");
	a_good_needs_target: assert property ($rose(channelGood[0]) |->
		$past(sense.ledChannelAtTarget[0], 2) || $past(sense.ledChannelAtTarget[0], 3))
		else $error("good without target current");
	a_trip_stops_all: assert property ({1'b0, currentDerate} == {1'b0, $past(currentDerate)} + 3'h1
		|-> channelEnable == '0 && !boostSwitchOn && deviceActive)
		else $error("trip left outputs on");
	a_inject_idle: assert property (boostSwitchNodeInject |-> channelEnable == '0
		&& !boostSwitchOn) else $error("operating before node check");
	a_shutdown_state: assert property (protectFetOff |-> !deviceActive && faultFlag)
		else $error("protection off without shutdown");
	a_chan_needs_active: assert property (channelEnable != '0 |-> deviceActive)
		else $error("channel on while inactive");
endmodule

bind lfm_fault_manager lfm_chk chk (.clk, .rst, .sense, .switchRequest, .switchOverLimit,
	.boostSwitchOn, .channelEnable, .channelGood, .currentDerate, .faultFlag, .protectFetOff,
	.boostSwitchNodeInject, .deviceActive);

// ---- tb/lfm_strings.sv ----
module lfm_strings (
	input wire logic clk,
	input wire logic [lfm_pkg::NUM_CH-1:0] chanOn,
	input wire logic inject,
	input wire logic [lfm_pkg::NUM_CH-1:0] openMask,
	output logic [lfm_pkg::NUM_CH-1:0] atTarget,
	output logic nodeHigh
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] chargeCnt = 2'h0;
	initial atTarget = '0;
	always @(posedge clk)
	begin
		if (!inject)
			chargeCnt <= 2'h0;
		else if (chargeCnt != 2'h3)
			chargeCnt <= chargeCnt + 2'h1;
		atTarget <= chanOn & ~openMask;
	end
	// injected current charges the node slowly
	assign nodeHigh = chargeCnt == 2'h3;
endmodule

// ---- tb/tb.sv ----
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
	$display("ERROR %s exp %0h got %0h", nm, e, g); end end
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic rst = 1'b1;
	lfm_pkg::lfm_in_s s = '0;
	lfm_pkg::lfm_in_s sense;
	logic switchRequest = 1'b0, switchCycleStart = 1'b0, switchOverLimit = 1'b0;
	logic pwmCycleStart = 1'b0, boostSwitchOn, faultFlag, protectFetOff, inject, deviceActive;
	logic [5:0] channelEnable, channelGood, at, openMask = '0;
	logic [1:0] currentDerate;
	logic nodeHigh;
	int bad_count = 0, cmp_count = 0, seed;
	always #25 clk = ~clk;
	always_comb
	begin
		sense = s;
		sense.ledChannelAtTarget = at;
		sense.boostSwitchNodeHigh = nodeHigh;
	end
	lfm_fault_manager #(.ENABLE_LOW_CYCLES(20'h14), .OPEN_HOT_CYCLES(14'hA)) uut (.clk, .rst,
		.sense, .switchRequest, .switchCycleStart, .switchOverLimit, .pwmCycleStart,
		.boostSwitchOn, .channelEnable, .channelGood, .currentDerate, .faultFlag, .protectFetOff,
		.boostSwitchNodeInject(inject), .deviceActive);
	lfm_strings far (.clk, .chanOn(channelEnable), .inject, .openMask, .atTarget(at), .nodeHigh);
	task cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	function logic [1:0] expDerate(input int trips);
		return (trips > 3) ? 2'h3 : 2'(trips);
	endfunction
	task summarize;
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial
	begin
		cyc(4000);
		bad_count++;
		summarize;
	end
	initial
	begin
		seed = $urandom(32'h77011a1d);
		cyc(2);
		rst <= 1'b0;
		s.chipEnable <= 1'b1;
		cyc(4);
		`CHK("inject", 1'b1, inject)
		for (int i = 0; i < 50 && channelEnable !== 6'h3F; i++) cyc(1);
		cyc(6);
		`CHK("good", 6'h3F, channelGood)
		$display("test start done");
		repeat (40)
		begin
			@(posedge clk);
			switchRequest <= 1'($urandom);
			switchCycleStart <= 1'($urandom);
			switchOverLimit <= ($urandom % 4) == 0;
		end
		@(posedge clk);
		switchRequest <= 1'b1;
		switchOverLimit <= 1'b0;
		switchCycleStart <= 1'b1;
		@(posedge clk);
		switchCycleStart <= 1'b0;
		cyc(1);
		`CHK("switch", 1'b1, boostSwitchOn)
		switchOverLimit <= 1'b1;
		@(posedge clk);
		switchOverLimit <= 1'b0;
		cyc(2);
		`CHK("switch", 1'b0, boostSwitchOn)
		$display("test switch done");
		openMask <= 6'h04;
		cyc(8);
		`CHK("good", 6'h3B, channelGood)
		repeat (6)
		begin
			@(posedge clk);
			pwmCycleStart <= 1'b1;
			@(posedge clk);
			pwmCycleStart <= 1'b0;
		end
		cyc(4);
		`CHK("enable", 6'h3B, channelEnable)
		`CHK("fault", 1'b1, faultFlag)
		$display("test open done");
		s.channelShortDetect[0] <= 1'b1;
		cyc(3);
		repeat (5)
		begin
			@(posedge clk);
			pwmCycleStart <= 1'b1;
			@(posedge clk);
			pwmCycleStart <= 1'b0;
		end
		cyc(2);
		`CHK("enable", 6'h3B, channelEnable)
		@(posedge clk);
		pwmCycleStart <= 1'b1;
		@(posedge clk);
		pwmCycleStart <= 1'b0;
		cyc(4);
		`CHK("enable", 6'h3A, channelEnable)
		s.channelShortDetect[0] <= 1'b0;
		$display("test short done");
		s.tempLower <= 1'b1;
		openMask <= 6'h0C;
		cyc(12);
		`CHK("enable", 6'h3A, channelEnable)
		cyc(5);
		`CHK("enable", 6'h32, channelEnable)
		s.tempLower <= 1'b0;
		cyc(2);
		$display("test hot open done");
		for (int t = 1; t <= 4; t++)
		begin
			s.tempUpper <= 1'b1;
			cyc(5);
			`CHK("derate", expDerate(t), currentDerate)
			`CHK("enable", 6'h00, channelEnable)
			`CHK("active", 1'b1, deviceActive)
			s.tempUpper <= 1'b0;
			s.tempCooled <= 1'b1;
			cyc(5);
			s.tempCooled <= 1'b0;
			cyc(6);
		end
		$display("test thermal done");
		s.overvoltageSenseHigh <= 1'b1;
		cyc(5);
		s.overvoltageSenseHigh <= 1'b0;
		cyc(5);
		`CHK("fetoff", 1'b1, protectFetOff)
		$display("test sense done");
		s.chipEnable <= 1'b0;
		cyc(30);
		`CHK("active", 1'b0, deviceActive)
		`CHK("fault", 1'b1, faultFlag)
		s.supplyLockout <= 1'b1;
		cyc(5);
		`CHK("fault", 1'b0, faultFlag)
		$display("test shutdown done");
		summarize;
	end
endmodule
